// ===== bench/isa_chk.sv
// checker of the arbiter's service offers and bus answer
// assumes: bound into isa_top, one clock, async low reset
`timescale 1ns/1ps
module isa_chk (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        global_irq_enable,
	input wire logic        svc_accept,
	input wire logic        svc_valid,
	input wire logic [1:0]  svc_mode,
	input wire logic [4:0]  svc_source,
	input wire logic [7:0]  svc_vector,
	input wire logic [15:0] svc_macro_addr,
	input wire logic        svc_save_stack,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	wire rq = avs_read | avs_write;
	property p_vec;
		svc_valid && svc_source < 5'h16 |-> svc_vector == 8'h06 + {2'h0, svc_source, 1'b0};
	endproperty
	a_vec: assert property (p_vec) else $error("maskable vector wrong");
	property p_macro;
		svc_valid && svc_mode == 2'h2 |-> svc_macro_addr == 16'hfe06 + {10'h0, svc_source, 1'b0};
	endproperty
	a_macro: assert property (p_macro) else $error("control word address wrong");
	property p_noerrm;
		svc_valid && svc_source == 5'h0e |-> svc_mode != 2'h2;
	endproperty
	a_noerrm: assert property (p_noerrm) else $error("receive error in macro mode");
	property p_ie;
		$rose(svc_valid) && svc_mode != 2'h2 && svc_source < 5'h16 |-> $past(global_irq_enable);
	endproperty
	a_ie: assert property (p_ie) else $error("maskable offer while disabled");
	property p_stack;
		svc_valid |-> svc_save_stack == (svc_mode == 2'h0);
	endproperty
	a_stack: assert property (p_stack) else $error("stack save flag wrong");
	property p_nmi;
		svc_valid && svc_source[4:1] == 4'hc |-> svc_vector == {5'h0, svc_source[0], ~svc_source[0], 1'b0};
	endproperty
	a_nmi: assert property (p_nmi) else $error("nmi vector wrong");
	property p_operr;
		svc_valid && svc_source == 5'h1a |-> svc_vector == 8'h3c;
	endproperty
	a_operr: assert property (p_operr) else $error("operand error vector wrong");
	property p_brk;
		svc_valid && svc_source == 5'h1b |-> svc_vector == 8'h3e && svc_mode == 2'h0;
	endproperty
	a_brk: assert property (p_brk) else $error("break offer wrong");
	property p_hold;
		svc_valid && !svc_accept |=> svc_valid && $stable(svc_source) && $stable(svc_vector);
	endproperty
	a_hold: assert property (p_hold) else $error("offer changed before accept");
	property p_drop;
		svc_valid && svc_accept |=> !svc_valid;
	endproperty
	a_drop: assert property (p_drop) else $error("offer kept after accept");
	property p_wait;
		rq && !$past(rq) |-> avs_waitrequest ##1 !avs_waitrequest;
	endproperty
	a_wait: assert property (p_wait) else $error("bus answer timing wrong");
	c_macro: cover property (svc_valid && svc_mode == 2'h2);
	c_ctx: cover property (svc_valid && svc_mode == 2'h1);
	c_nmi: cover property (svc_valid && svc_source == 5'h19);
endmodule
bind isa_top isa_chk isa_chk_inst (
	.clk(clk), .resetn(resetn), .global_irq_enable(global_irq_enable),
	.svc_accept(svc_accept), .svc_valid(svc_valid), .svc_mode(svc_mode),
	.svc_source(svc_source), .svc_vector(svc_vector), .svc_macro_addr(svc_macro_addr),
	.svc_save_stack(svc_save_stack), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest)
);

// ===== bench/isa_cpu_model.sv
// cpu side model: raises accept lag+1 cycles after each offer appears
// assumes: offers hold until taken, one clock, async low reset
`timescale 1ns/1ps
module isa_cpu_model (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       svc_valid,
	input  wire logic [3:0] lag,
	output logic            svc_accept
);
	logic [3:0] cnt_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q      <= 4'h0;
			svc_accept <= 1'b0;
		end else begin
			svc_accept <= svc_valid && !svc_accept && cnt_q == lag;
			cnt_q      <= (svc_valid && !svc_accept) ? cnt_q + 4'h1 : 4'h0;
		end
	end
endmodule

// ===== bench/isa_top_tb.sv
// self-checking bench of the interrupt source arbiter
// assumes: cpu model takes every offer; event pulses come from ev
`timescale 1ns/1ps
module isa_top_tb;
	logic        clk, resetn, ie, s1m, s2m, nmi, acc, q, avs_read, avs_write;
	logic        svc_valid, svc_save_stack, avs_waitrequest;
	logic [31:0] ev, avs_writedata, rd, avs_readdata;
	logic [15:0] svc_macro_addr;
	logic [7:0]  avs_address, svc_vector;
	logic [4:0]  svc_source;
	logic [3:0]  lag, be;
	logic [2:0]  bank, svc_bank;
	logic [1:0]  svc_mode, svc_level, el;
	int          n_fail, checks, j;
	isa_top isa_top_inst (.clk(clk), .resetn(resetn), .low_req(ev[31:23]),
		.timer2_match1_req(ev[0]), .timer3_match_req(ev[1]), .edge_pin4_req(ev[2]),
		.edge_pin5_req(ev[3]), .conversion_done_req(ev[4]), .async1_rx_error_req(ev[5]),
		.async1_rx_end_req(ev[6]), .clocked1_xfer_end_req(ev[7]), .serial1_clocked_mode(s1m),
		.async1_tx_end_req(ev[8]), .clocked0_xfer_end_req(ev[9]), .async2_rx_error_req(ev[10]),
		.async2_rx_end_req(ev[11]), .clocked2_xfer_end_req(ev[12]), .serial2_clocked_mode(s2m),
		.async2_tx_end_req(ev[13]), .bus_stop_cond_req(ev[14]), .nmi_pin(nmi),
		.watchdog_overflow_req(ev[15]), .vectored_break_instr(ev[16]),
		.switching_break_instr(ev[17]), .switching_break_bank(bank),
		.standby_control_bad(ev[18]), .watchdog_mode_bad(ev[19]),
		.memory_placement_bad(ev[20]), .global_irq_enable(ie), .svc_accept(acc),
		.irq_return(ev[21]), .nmi_return(ev[22]), .svc_valid(svc_valid), .svc_mode(svc_mode),
		.svc_source(svc_source), .svc_vector(svc_vector), .svc_macro_addr(svc_macro_addr),
		.svc_bank(svc_bank), .svc_level(svc_level), .svc_save_stack(svc_save_stack),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(be), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	isa_cpu_model isa_cpu_model_inst (.clk(clk), .resetn(resetn), .svc_valid(svc_valid),
		.lag(lag), .svc_accept(acc));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task close_out;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task tmo;
		n_fail++;
		close_out;
	endtask
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task xfer(input logic [7:0] a, input logic [31:0] d, input logic w);
		int i;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (avs_waitrequest === 1'b0) break;
		end
		if (i == 20) tmo;
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task pulse(input logic [31:0] m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= 32'h0;
	endtask
	task quiet(input int n);
		q = 1'b0;
		repeat (n) begin
			@(posedge clk);
			#1 q = q | svc_valid;
		end
		chk("no offer", q, 1'b0);
	endtask
	task offer(input logic [1:0] m, input logic [4:0] s, input logic [7:0] v,
		input logic k, input logic [2:0] b);
		int i;
		for (i = 0; i < 40; i++) begin
			@(posedge clk);
			#1 if (svc_valid === 1'b1) break;
		end
		if (i == 40) tmo;
		chk("offer", {svc_valid, svc_mode, svc_source, svc_vector, svc_save_stack, svc_bank,
			svc_level}, {1'b1, m, s, v, k, b, el});
		for (i = 0; i < 40; i++) begin
			@(posedge clk);
			#1 if (svc_valid === 1'b0) break;
		end
		if (i == 40) tmo;
	endtask
	task t_reset;
		xfer(8'h28, 32'h0, 1'b0);
		chk("slot reset", rd, 32'he);
		xfer(8'h68, 32'hff, 1'b1);
		xfer(8'h68, 32'h0, 1'b0);
		chk("unmapped", rd, 32'h0);
		xfer(8'h60, 32'h0, 1'b0);
		chk("status reset", rd, 32'h0);
		ie <= 1'b1;
		pulse(32'h2);
		quiet(8);
		$display("reset test done");
	endtask
	task t_vec;
		lag <= 4'h4;
		el = 2'h2;
		bw_lvl();
		pulse(32'h1);
		quiet(8);
		xfer(8'h24, 32'h9, 1'b1);
		offer(2'h0, 5'h09, 8'h18, 1'b1, 3'h0);
		pulse(32'h2);
		quiet(8);
		xfer(8'h2c, 32'h4, 1'b1);
		pulse(32'h4);
		el = 2'h1;
		offer(2'h0, 5'h0b, 8'h1c, 1'b1, 3'h0);
		el = 2'h2;
		pulse(32'h1 << 21);
		quiet(6);
		pulse(32'h1 << 21);
		offer(2'h0, 5'h0a, 8'h1a, 1'b1, 3'h0);
		pulse(32'h1 << 21);
		ie <= 1'b0;
		pulse(32'h1);
		quiet(8);
		@(posedge clk);
		ie <= 1'b1;
		offer(2'h0, 5'h09, 8'h18, 1'b1, 3'h0);
		pulse(32'h1 << 21);
		lag <= 4'h0;
		$display("vectored test done");
	endtask
	task bw_lvl;
		xfer(8'h28, 32'h8, 1'b1);
	endtask
	task t_prio;
		xfer(8'h00, 32'h8, 1'b1);
		xfer(8'h30, 32'h8, 1'b1);
		pulse(32'h00800008);
		offer(2'h0, 5'h00, 8'h06, 1'b1, 3'h0);
		pulse(32'h1 << 21);
		offer(2'h0, 5'h0c, 8'h1e, 1'b1, 3'h0);
		pulse(32'h1 << 21);
		xfer(8'h34, 32'h0, 1'b1);
		pulse(32'h18);
		el = 2'h0;
		offer(2'h0, 5'h0d, 8'h20, 1'b1, 3'h0);
		pulse(32'h1 << 21);
		el = 2'h2;
		offer(2'h0, 5'h0c, 8'h1e, 1'b1, 3'h0);
		pulse(32'h1 << 21);
		el = 2'h0;
		$display("priority test done");
	endtask
	task t_macro;
		xfer(8'h28, 32'h10, 1'b1);
		ie <= 1'b0;
		pulse(32'h2);
		offer(2'h2, 5'h0a, 8'h1a, 1'b0, 3'h0);
		xfer(8'h38, 32'h10, 1'b1);
		xfer(8'h38, 32'h0, 1'b0);
		chk("rx error macro", rd[4], 1'b0);
		ie <= 1'b1;
		pulse(32'h20);
		offer(2'h0, 5'h0e, 8'h22, 1'b1, 3'h0);
		pulse(32'h1 << 21);
		xfer(8'h40, 32'h320, 1'b1);
		pulse(32'h100);
		offer(2'h1, 5'h10, 8'h26, 1'b0, 3'h3);
		pulse(32'h1 << 21);
		$display("macro test done");
	endtask
	task t_serial;
		xfer(8'h3c, 32'h0, 1'b1);
		xfer(8'h4c, 32'h0, 1'b1);
		pulse(32'h40);
		offer(2'h0, 5'h0f, 8'h24, 1'b1, 3'h0);
		pulse(32'h1 << 21);
		pulse(32'h80);
		quiet(6);
		s1m <= 1'b1;
		s2m <= 1'b1;
		pulse(32'h80);
		offer(2'h0, 5'h0f, 8'h24, 1'b1, 3'h0);
		pulse(32'h1 << 21);
		pulse(32'h1000);
		offer(2'h0, 5'h13, 8'h2c, 1'b1, 3'h0);
		pulse(32'h1 << 21);
		pulse(32'h800);
		quiet(6);
		xfer(8'h54, 32'h10, 1'b1);
		pulse(32'h4000);
		offer(2'h2, 5'h15, 8'h30, 1'b0, 3'h0);
		$display("serial test done");
	endtask
	task t_nmi;
		xfer(8'h28, 32'h0, 1'b1);
		pulse(32'h8002);
		offer(2'h0, 5'h19, 8'h04, 1'b1, 3'h0);
		offer(2'h0, 5'h0a, 8'h1a, 1'b1, 3'h0);
		pulse(32'h1 << 21);
		pulse(32'h8000);
		quiet(8);
		@(posedge clk);
		nmi <= 1'b1;
		offer(2'h0, 5'h18, 8'h02, 1'b1, 3'h0);
		pulse(32'h1 << 22);
		quiet(6);
		pulse(32'h1 << 22);
		offer(2'h0, 5'h19, 8'h04, 1'b1, 3'h0);
		pulse(32'h1 << 22);
		nmi <= 1'b0;
		xfer(8'h64, 32'h1, 1'b1);
		xfer(8'h64, 32'h0, 1'b0);
		chk("wdt first", rd, 32'h1);
		nmi <= 1'b1;
		offer(2'h0, 5'h18, 8'h02, 1'b1, 3'h0);
		pulse(32'h8000);
		offer(2'h0, 5'h19, 8'h04, 1'b1, 3'h0);
		pulse(32'h1 << 22);
		pulse(32'h1 << 22);
		nmi <= 1'b0;
		$display("nmi test done");
	endtask
	task t_soft;
		ie <= 1'b0;
		bank <= 3'h5;
		pulse(32'h1 << 16);
		offer(2'h0, 5'h1b, 8'h3e, 1'b1, 3'h0);
		pulse(32'h1 << 17);
		offer(2'h1, 5'h1c, 8'h00, 1'b0, 3'h5);
		for (j = 18; j < 21; j++) begin
			pulse(32'h1 << j);
			offer(2'h0, 5'h1a, 8'h3c, 1'b1, 3'h0);
		end
		$display("software test done");
	endtask
	initial begin
		resetn = 1'b0;
		ie = 1'b0;
		s1m = 1'b0;
		s2m = 1'b0;
		nmi = 1'b0;
		ev = 32'h0;
		bank = 3'h0;
		el = 2'h0;
		lag = 4'h0;
		be = 4'hf;
		avs_address = 8'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		n_fail = 0;
		checks = 0;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		t_reset;
		t_vec;
		t_prio;
		t_macro;
		t_serial;
		t_nmi;
		t_soft;
		close_out;
	end
endmodule

// ===== hw/isa_pick.sv
// level-first, default-priority-second picker over pending requests
// assumes: level 0 is the highest level, index 0 the highest default priority
`timescale 1ns/1ps
module isa_pick #(
	parameter int N = 22
) (
	input  wire logic [N-1:0]      req,
	input  wire logic [N-1:0][1:0] lvl,
	output logic                   found,
	output logic [4:0]             idx,
	output logic [1:0]             idx_lvl
);

	initial begin
		if (N < 1 || N > 32) begin
			$error("isa_pick: N out of range");
		end
	end

	// walk downward so that on equal level the lower index replaces
	always_comb begin
		found   = 1'b0;
		idx     = 5'h00;
		idx_lvl = 2'h3;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i] && (!found || lvl[i] <= idx_lvl)) begin
				found   = 1'b1;
				idx     = 5'(i);
				idx_lvl = lvl[i];
			end
		end
	end

endmodule

// ===== hw/isa_pkg.sv
// constants, encodings and helpers of the interrupt source arbiter
// assumes: single clock domain, byte-addressed Avalon-MM register window
package isa_pkg;

	localparam int NSRC  = 22;
	localparam int SRC_W = 5;

	// fixed vector table entries
	localparam logic [7:0]  VEC_NMI_PIN   = 8'h02;
	localparam logic [7:0]  VEC_WDT       = 8'h04;
	localparam logic [7:0]  VEC_MASK_BASE = 8'h06;
	localparam logic [7:0]  VEC_OPERR     = 8'h3c;
	localparam logic [7:0]  VEC_BRK       = 8'h3e;
	localparam logic [15:0] MACRO_BASE    = 16'hfe06;

	// default priority numbers of special maskable slots
	localparam int SRC_RX_ERR1  = 14;
	localparam int SRC_RX_END1  = 15;
	localparam int SRC_RX_END2  = 19;
	localparam int SRC_BUS_STOP = 21;

	// source codes reported for non-maskable and software services
	localparam logic [4:0] CODE_NMI_PIN = 5'h18;
	localparam logic [4:0] CODE_WDT     = 5'h19;
	localparam logic [4:0] CODE_OPERR   = 5'h1a;
	localparam logic [4:0] CODE_BRK     = 5'h1b;
	localparam logic [4:0] CODE_SWITCHING_BREAK_INSTR   = 5'h1c;

	// register map (byte addresses)
	localparam int         ADDR_W     = 8;
	localparam logic [7:0] REG_SRC    = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h60;
	localparam logic [7:0] REG_CTRL   = 8'h64;

	// source control word fields
	localparam int F_FLAG  = 0;
	localparam int F_MASK  = 1;
	localparam int F_LVL   = 2;
	localparam int F_MACRO = 4;
	localparam int F_CSE   = 5;
	localparam int F_BANK  = 8;
	// status fields
	localparam int S_ISR   = 0;
	localparam int S_NMI   = 4;
	localparam int S_VALID = 6;
	// control fields
	localparam int C_WDT_FIRST = 0;

	// reset values
	localparam logic       RST_MASK = 1'b1;
	localparam logic [1:0] RST_LVL  = 2'h3;

	typedef enum logic [1:0] {
		MODE_VECTORED = 2'b00,
		MODE_CONTEXT  = 2'b01,
		MODE_MACRO    = 2'b10
	} isa_mode_type;

	typedef enum logic {
		ST_IDLE  = 1'b0,
		ST_OFFER = 1'b1
	} isa_state_type;

	function automatic logic [7:0] vec_of(input logic [4:0] idx);
		vec_of = VEC_MASK_BASE + {2'h0, idx, 1'b0};
	endfunction

	function automatic logic [15:0] macro_of(input logic [4:0] idx);
		macro_of = MACRO_BASE + {10'h000, idx, 1'b0};
	endfunction

endpackage

// ===== hw/isa_top.sv
// interrupt source arbiter: latches, masks, ranks and offers interrupt services
// assumes: request pulses come from logic on clk; nmi_pin comes from a pin
//
// Notes on behaviour
// - maskable vectors run 06h upward, two per step
// - macro control words run 0fe06h upward, two per step
// - default priority only breaks equal-level ties
// - serial receive slots shared, mode picks meaning
// - async1 receive-error slot never uses macro service
// - bus stop slot only on two-wire variant
// - break instructions bypass enable and arbitration
// - illegal operands raise operand error interrupt
// - pin edge or watchdog overflow make nmi
// - nmi held while same or higher serviced
// - nmi outranks everything, no programmable level
// - masked source is never acknowledged
// - global enable gates vectored and context service
// - four levels, higher level nests over lower
// - macro service ignores levels and global enable
// - per source choice of vectored, context, macro
// - vectored service saves pc and psw on stack
// - macro service saves nothing, only suspends
// - nmi pin vector 2h, watchdog 4h
// - operand error vector 3ch
// - context switch selects bank, saves into it
`timescale 1ns/1ps
module isa_top #(
	parameter bit HAS_TWO_WIRE = 1'b1
) (
	input  wire logic                      clk,
	input  wire logic                      resetn,
	input  wire logic [8:0]                low_req,
	input  wire logic                      timer2_match1_req,
	input  wire logic                      timer3_match_req,
	input  wire logic                      edge_pin4_req,
	input  wire logic                      edge_pin5_req,
	input  wire logic                      conversion_done_req,
	input  wire logic                      async1_rx_error_req,
	input  wire logic                      async1_rx_end_req,
	input  wire logic                      clocked1_xfer_end_req,
	input  wire logic                      serial1_clocked_mode,
	input  wire logic                      async1_tx_end_req,
	input  wire logic                      clocked0_xfer_end_req,
	input  wire logic                      async2_rx_error_req,
	input  wire logic                      async2_rx_end_req,
	input  wire logic                      clocked2_xfer_end_req,
	input  wire logic                      serial2_clocked_mode,
	input  wire logic                      async2_tx_end_req,
	input  wire logic                      bus_stop_cond_req,
	input  wire logic                      nmi_pin,
	input  wire logic                      watchdog_overflow_req,
	input  wire logic                      vectored_break_instr,
	input  wire logic                      switching_break_instr,
	input  wire logic [2:0]                switching_break_bank,
	input  wire logic                      standby_control_bad,
	input  wire logic                      watchdog_mode_bad,
	input  wire logic                      memory_placement_bad,
	input  wire logic                      global_irq_enable,
	input  wire logic                      svc_accept,
	input  wire logic                      irq_return,
	input  wire logic                      nmi_return,
	output logic                           svc_valid,
	output logic [1:0]                     svc_mode,
	output logic [4:0]                     svc_source,
	output logic [7:0]                     svc_vector,
	output logic [15:0]                    svc_macro_addr,
	output logic [2:0]                     svc_bank,
	output logic [1:0]                     svc_level,
	output logic                           svc_save_stack,
	input  wire logic [isa_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                      avs_read,
	input  wire logic                      avs_write,
	input  wire logic [31:0]               avs_writedata,
	input  wire logic [3:0]                avs_byteenable,
	output logic [31:0]                    avs_readdata,
	output logic                           avs_waitrequest
);

	localparam int N = isa_pkg::NSRC;

	initial begin
		if (N != 22) begin
			$error("isa_top: source count must be 22");
		end
	end

	typedef struct packed {
		isa_pkg::isa_state_type st;
		logic                   ack;
		logic [31:0]            rdata;
		logic [N-1:0]           flag;
		logic [N-1:0]           mask;
		logic [N-1:0]           macro;
		logic [N-1:0]           cse;
		logic [N-1:0][1:0]      lvl;
		logic [N-1:0][2:0]      bank;
		logic [3:0]             isr;
		logic [1:0]             nmi_isr;
		logic [1:0]             nmi_pend;
		logic                   op_pend;
		logic                   brk_pend;
		logic                   switching_break_instr_pend;
		logic [2:0]             switching_break_instr_bank;
		logic                   wdt_first;
		logic [2:0]             nmi_sync;
		logic [1:0]             mode;
		logic [4:0]             src;
		logic [7:0]             vec;
		logic [15:0]            maddr;
		logic [2:0]             obank;
		logic [1:0]             olvl;
		logic                   stack;
	} isa_regs_type;

	isa_regs_type q;
	isa_regs_type d;

	logic [N-1:0]      req_in;
	logic [N-1:0]      present;
	logic [N-1:0]      macro_ok;
	logic [N-1:0]      vec_cand;
	logic [N-1:0]      mac_cand;
	logic [N-1:0][1:0] zero_lvl;
	logic              vec_found;
	logic [4:0]        vec_idx;
	logic [1:0]        vec_lvl;
	logic              mac_found;
	logic [4:0]        mac_idx;
	logic              nmi_edge;
	logic              nmi_hi;
	logic [1:0]        nmi_ok;
	logic              vec_beats_isr;
	logic              bus_req;
	logic              src_hit;
	logic [4:0]        src_sel;

	// mapping of peripheral events onto default-priority slots
	always_comb begin
		req_in                        = '0;
		req_in[8:0]                   = low_req;
		req_in[9]                     = timer2_match1_req;
		req_in[10]                    = timer3_match_req;
		req_in[11]                    = edge_pin4_req;
		req_in[12]                    = edge_pin5_req;
		req_in[13]                    = conversion_done_req;
		req_in[isa_pkg::SRC_RX_ERR1]  = async1_rx_error_req;
		req_in[isa_pkg::SRC_RX_END1]  = serial1_clocked_mode ? clocked1_xfer_end_req
		                                                     : async1_rx_end_req;
		req_in[16]                    = async1_tx_end_req;
		req_in[17]                    = clocked0_xfer_end_req;
		req_in[18]                    = async2_rx_error_req;
		req_in[isa_pkg::SRC_RX_END2]  = serial2_clocked_mode ? clocked2_xfer_end_req
		                                                     : async2_rx_end_req;
		req_in[20]                    = async2_tx_end_req;
		req_in[isa_pkg::SRC_BUS_STOP] = bus_stop_cond_req & HAS_TWO_WIRE;
	end

	always_comb begin
		present                        = '1;
		present[isa_pkg::SRC_BUS_STOP] = HAS_TWO_WIRE;
		macro_ok                       = present;
		macro_ok[isa_pkg::SRC_RX_ERR1] = 1'b0;
	end

	assign zero_lvl = '0;
	assign mac_cand = q.flag & ~q.mask & q.macro & macro_ok;
	assign vec_cand = q.flag & ~q.mask & ~(q.macro & macro_ok) & present;

	// macro requests rank by default priority only
	isa_pick #(
		.N(N)
	) u_pick_macro (
		.req     (mac_cand),
		.lvl     (zero_lvl),
		.found   (mac_found),
		.idx     (mac_idx),
		.idx_lvl ()
	);

	isa_pick #(
		.N(N)
	) u_pick_vec (
		.req     (vec_cand),
		.lvl     (q.lvl),
		.found   (vec_found),
		.idx     (vec_idx),
		.idx_lvl (vec_lvl)
	);

	// a level is blocked by any in-service level at or above it
	always_comb begin
		vec_beats_isr = 1'b1;
		for (int l = 0; l < 4; l++) begin
			if (q.isr[l] && 2'(l) <= vec_lvl) begin
				vec_beats_isr = 1'b0;
			end
		end
	end

	// nmi index 0 is the pin, 1 the watchdog
	assign nmi_edge  = q.nmi_sync[1] & ~q.nmi_sync[2];
	assign nmi_hi    = q.wdt_first;
	assign nmi_ok[0] = q.nmi_pend[0] & ~q.nmi_isr[0] & ~(q.nmi_isr[1] & nmi_hi);
	assign nmi_ok[1] = q.nmi_pend[1] & ~q.nmi_isr[1] & ~(q.nmi_isr[0] & ~nmi_hi);

	assign bus_req = avs_read | avs_write;
	assign src_sel = avs_address[6:2];
	assign src_hit = ~avs_address[7] && (avs_address[1:0] == 2'h0) && (src_sel < 5'(N));

	always_comb begin
		d          = q;
		d.nmi_sync = {q.nmi_sync[1:0], nmi_pin};
		d.ack      = bus_req & ~q.ack;

		// read data captured one edge ahead of the answer
		if (avs_read && !q.ack) begin
			d.rdata = 32'h0000_0000;
			if (src_hit && present[src_sel]) begin
				d.rdata[isa_pkg::F_FLAG]           = q.flag[src_sel];
				d.rdata[isa_pkg::F_MASK]           = q.mask[src_sel];
				d.rdata[isa_pkg::F_LVL +: 2]       = q.lvl[src_sel];
				d.rdata[isa_pkg::F_MACRO]          = q.macro[src_sel];
				d.rdata[isa_pkg::F_CSE]            = q.cse[src_sel];
				d.rdata[isa_pkg::F_BANK +: 3]      = q.bank[src_sel];
			end else if (avs_address == isa_pkg::REG_STATUS) begin
				d.rdata[isa_pkg::S_ISR +: 4]       = q.isr;
				d.rdata[isa_pkg::S_NMI +: 2]       = q.nmi_isr;
				d.rdata[isa_pkg::S_VALID]          = (q.st == isa_pkg::ST_OFFER);
			end else if (avs_address == isa_pkg::REG_CTRL) begin
				d.rdata[isa_pkg::C_WDT_FIRST]      = q.wdt_first;
			end
		end

		// writes land one edge after the wait ends, on the answer edge
		if (avs_write && q.ack) begin
			if (src_hit && present[src_sel]) begin
				if (avs_byteenable[0]) begin
					d.flag[src_sel]  = avs_writedata[isa_pkg::F_FLAG];
					d.mask[src_sel]  = avs_writedata[isa_pkg::F_MASK];
					d.lvl[src_sel]   = avs_writedata[isa_pkg::F_LVL +: 2];
					d.macro[src_sel] = avs_writedata[isa_pkg::F_MACRO] & macro_ok[src_sel];
					d.cse[src_sel]   = avs_writedata[isa_pkg::F_CSE];
				end
				if (avs_byteenable[1]) begin
					d.bank[src_sel] = avs_writedata[isa_pkg::F_BANK +: 3];
				end
			end else if (avs_address == isa_pkg::REG_CTRL && avs_byteenable[0]) begin
				d.wdt_first = avs_writedata[isa_pkg::C_WDT_FIRST];
			end
		end

		// service ends: drop the highest active level or nmi
		if (irq_return) begin
			for (int l = 3; l >= 0; l--) begin
				if (q.isr[l]) begin
					d.isr = q.isr & ~(4'h1 << l);
				end
			end
		end
		if (nmi_return) begin
			if (q.nmi_isr[nmi_hi]) begin
				d.nmi_isr[nmi_hi] = 1'b0;
			end else begin
				d.nmi_isr[~nmi_hi] = 1'b0;
			end
		end

		case (q.st)
			isa_pkg::ST_IDLE: begin
				d.stack = 1'b0;
				d.olvl  = 2'h0;
				d.obank = 3'h0;
				d.maddr = 16'h0000;
				d.st    = isa_pkg::ST_OFFER;
				if (nmi_ok[nmi_hi]) begin
					d.mode  = isa_pkg::MODE_VECTORED;
					d.src   = nmi_hi ? isa_pkg::CODE_WDT : isa_pkg::CODE_NMI_PIN;
					d.vec   = nmi_hi ? isa_pkg::VEC_WDT : isa_pkg::VEC_NMI_PIN;
					d.stack = 1'b1;
				end else if (nmi_ok[~nmi_hi]) begin
					d.mode  = isa_pkg::MODE_VECTORED;
					d.src   = nmi_hi ? isa_pkg::CODE_NMI_PIN : isa_pkg::CODE_WDT;
					d.vec   = nmi_hi ? isa_pkg::VEC_NMI_PIN : isa_pkg::VEC_WDT;
					d.stack = 1'b1;
				end else if (q.op_pend) begin
					d.mode  = isa_pkg::MODE_VECTORED;
					d.src   = isa_pkg::CODE_OPERR;
					d.vec   = isa_pkg::VEC_OPERR;
					d.stack = 1'b1;
				end else if (q.brk_pend) begin
					d.mode  = isa_pkg::MODE_VECTORED;
					d.src   = isa_pkg::CODE_BRK;
					d.vec   = isa_pkg::VEC_BRK;
					d.stack = 1'b1;
				end else if (q.switching_break_instr_pend) begin
					d.mode  = isa_pkg::MODE_CONTEXT;
					d.src   = isa_pkg::CODE_SWITCHING_BREAK_INSTR;
					d.vec   = 8'h00;
					d.obank = q.switching_break_instr_bank;
				end else if (mac_found) begin
					d.mode  = isa_pkg::MODE_MACRO;
					d.src   = mac_idx;
					d.vec   = isa_pkg::vec_of(mac_idx);
					d.maddr = isa_pkg::macro_of(mac_idx);
				end else if (vec_found && vec_beats_isr && global_irq_enable) begin
					d.src  = vec_idx;
					d.olvl = vec_lvl;
					d.vec  = isa_pkg::vec_of(vec_idx);
					if (q.cse[vec_idx]) begin
						d.mode  = isa_pkg::MODE_CONTEXT;
						d.obank = q.bank[vec_idx];
					end else begin
						d.mode  = isa_pkg::MODE_VECTORED;
						d.stack = 1'b1;
					end
				end else begin
					d.st = isa_pkg::ST_IDLE;
				end
			end
			isa_pkg::ST_OFFER: begin
				if (svc_accept) begin
					d.st = isa_pkg::ST_IDLE;
					case (q.src)
						isa_pkg::CODE_NMI_PIN: begin
							d.nmi_pend[0] = 1'b0;
							d.nmi_isr[0]  = 1'b1;
						end
						isa_pkg::CODE_WDT: begin
							d.nmi_pend[1] = 1'b0;
							d.nmi_isr[1]  = 1'b1;
						end
						isa_pkg::CODE_OPERR: d.op_pend    = 1'b0;
						isa_pkg::CODE_BRK:   d.brk_pend   = 1'b0;
						isa_pkg::CODE_SWITCHING_BREAK_INSTR: d.switching_break_instr_pend = 1'b0;
						default: begin
							d.flag[q.src] = 1'b0;
							if (q.mode != isa_pkg::MODE_MACRO) begin
								d.isr[q.olvl] = 1'b1;
							end
						end
					endcase
				end
			end
			default: d.st = isa_pkg::ST_IDLE;
		endcase

		// new events win over any clear in the same cycle
		d.flag = d.flag | (req_in & present);
		if (nmi_edge) begin
			d.nmi_pend[0] = 1'b1;
		end
		if (watchdog_overflow_req) begin
			d.nmi_pend[1] = 1'b1;
		end
		if (standby_control_bad || watchdog_mode_bad || memory_placement_bad) begin
			d.op_pend = 1'b1;
		end
		if (vectored_break_instr) begin
			d.brk_pend = 1'b1;
		end
		if (switching_break_instr) begin
			d.switching_break_instr_pend = 1'b1;
			d.switching_break_instr_bank = switching_break_bank;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q      <= '0;
			q.mask <= {N{isa_pkg::RST_MASK}};
			q.lvl  <= {N{isa_pkg::RST_LVL}};
		end else begin
			q <= d;
		end
	end

	assign svc_valid       = (q.st == isa_pkg::ST_OFFER);
	assign svc_mode        = q.mode;
	assign svc_source      = q.src;
	assign svc_vector      = q.vec;
	assign svc_macro_addr  = q.maddr;
	assign svc_bank        = q.obank;
	assign svc_level       = q.olvl;
	assign svc_save_stack  = q.stack;
	assign avs_readdata    = q.rdata;
	assign avs_waitrequest = bus_req & ~q.ack;

endmodule
